// ===== led_digit_segment_decoder.sv
// Multiplexed digit scan with per-digit hex decode or raw segment drive.
// Assumes the serial front end delivers byte writes while cs_n is low.
//
// What this block does
// - A decode-select register at 0x01 holds one bit per digit, and a 1 selects hex decoding for that digit.
// - A digit whose select bit is 0, or every digit when the register is 0x00, shows its data as raw segments.
// - A decoded digit ignores D6-D4 and maps D3..D0 to segments a..g through the sixteen-character font.
// - A decoded digit lights the point segment whenever D7 is 1, whatever the character.
// - An undecoded digit drives point from D7 and a..g from D6..D0, a 1 lighting the segment.
// - Writing the control register with the sync bit set also restarts the multiplex sequence.
// - Blink timing is a division of the multiplex clock, giving 0.5Hz slow and 1Hz fast at 4MHz.
// - With the sync bit set, multiplex and blink counters clear on the cs_n rising edge ending the write.
`timescale 1ns/100ps
`default_nettype none
module led_digit_segment_decoder
   import led_digit_pkg::*;
#(
   parameter int SLOW_HALF = BLINK_SLOW_HALF,
   parameter int FAST_HALF = BLINK_FAST_HALF
)
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        wr_en,
   input  wire logic [7:0]  wr_addr,
   input  wire logic [7:0]  wr_data,
   input  wire logic        cs_n,
   input  wire logic        mux_clock_input,
   input  wire logic [7:0]  rd_addr,
   output logic      [7:0]  rd_data,
   output logic      [7:0]  segment_drive,
   output logic      [7:0]  digit_enable,
   output logic             blink_phase
);
   logic [7:0]             digit_decode_select_reg;
   logic [7:0]             control_reg;
   logic                   mux_prev_reg;
   logic                   cs_prev_reg;
   logic                   sync_arm_reg;
   logic [DIGIT_CNT_W-1:0] digit_cnt_reg;
   logic [2:0]             digit_idx_reg;
   logic [2:0]             idx_d1_reg;
   logic [BLINK_CNT_W-1:0] blink_cnt_reg;
   logic                   blink_phase_reg;
   logic [7:0]             segment_drive_reg;
   logic [7:0]             digit_enable_reg;
   logic [7:0]             rd_data_reg;
   logic [7:0]             mem_q;

   // Seven-segment font, bit 6 is segment a down to bit 0 segment g
   function automatic logic [6:0] hex_font(input logic [3:0] nib);
      logic [6:0] s;
      s = 7'h00;
      unique case (nib)
         4'h0: s = 7'h7e;
         4'h1: s = 7'h30;
         4'h2: s = 7'h6d;
         4'h3: s = 7'h79;
         4'h4: s = 7'h33;
         4'h5: s = 7'h5b;
         4'h6: s = 7'h5f;
         4'h7: s = 7'h70;
         4'h8: s = 7'h7f;
         4'h9: s = 7'h7b;
         4'ha: s = 7'h77;
         4'hb: s = 7'h1f;
         4'hc: s = 7'h4e;
         4'hd: s = 7'h3f;
         4'he: s = 7'h4f;
         4'hf: s = 7'h47;
      endcase
      return s;
   endfunction

   // Write decode and edge detection
   wire       sel_wr       = wr_en && (wr_addr == ADDR_DECODE_SELECT);
   wire       ctrl_wr      = wr_en && (wr_addr == ADDR_CONTROL);
   wire       digit_wr     = wr_en && (wr_addr[7:3] == ADDR_DIGIT_BASE[7:3]);
   wire       ctrl_wr_sync = ctrl_wr && wr_data[CTRL_SYNC_BIT];
   wire       mux_rise     = mux_clock_input && !mux_prev_reg;
   wire       cs_rise      = cs_n && !cs_prev_reg;
   wire       restart_now  = cs_rise && (sync_arm_reg || ctrl_wr_sync);
   wire       digit_wrap   = (digit_cnt_reg == DIGIT_CNT_W'(MUXCLK_PER_DIGIT - 1));
   wire [BLINK_CNT_W-1:0] blink_last = control_reg[CTRL_RATE_BIT] ?
                                       BLINK_CNT_W'(FAST_HALF - 1) : BLINK_CNT_W'(SLOW_HALF - 1);
   // Compare at or above so a rate change past the new end cannot stall the count
   wire       blink_wrap   = (blink_cnt_reg >= blink_last);

   // Segment formation on one common vector
   wire       decode_on    = digit_decode_select_reg[idx_d1_reg];
   wire [7:0] seg_decoded  = {mem_q[SEG_POINT_BIT], hex_font(mem_q[DIGIT_NIBBLE_MSB:0])};
   wire [7:0] seg_next     = decode_on ? seg_decoded : mem_q;
   wire [7:0] enable_next  = 8'h01 << idx_d1_reg;
   wire [7:0] status_word  = {4'h0, blink_phase_reg, digit_idx_reg};
   wire [7:0] rd_next      = (rd_addr == ADDR_DECODE_SELECT) ? digit_decode_select_reg :
                             (rd_addr == ADDR_CONTROL)       ? control_reg :
                             (rd_addr == ADDR_STATUS)        ? status_word : 8'h00;

   digit_store u_store
   (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .wr_en   (digit_wr),
      .wr_idx  (wr_addr[2:0]),
      .wr_data (wr_data),
      .rd_idx  (digit_idx_reg),
      .rd_q    (mem_q)
   );

   // Registers written by the host
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         digit_decode_select_reg <= DECODE_SELECT_RESET;
         control_reg             <= CONTROL_RESET;
      end
      else
      begin
         if (sel_wr)
         begin
            digit_decode_select_reg <= wr_data;
         end
         if (ctrl_wr)
         begin
            control_reg <= wr_data;
         end
      end
   end

   // Sync request held until chip select rises
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         mux_prev_reg <= 1'b0;
         cs_prev_reg  <= 1'b1;
         sync_arm_reg <= 1'b0;
      end
      else
      begin
         mux_prev_reg <= mux_clock_input;
         cs_prev_reg  <= cs_n;
         sync_arm_reg <= cs_rise ? 1'b0 : (sync_arm_reg || ctrl_wr_sync);
      end
   end

   // Multiplex and blink dividers on the multiplex clock
   always_ff @(posedge clk_sys)
   begin
      if (!rstn || restart_now)
      begin
         digit_cnt_reg   <= '0;
         digit_idx_reg   <= 3'h0;
         blink_cnt_reg   <= '0;
         blink_phase_reg <= 1'b0;
      end
      else if (mux_rise)
      begin
         digit_cnt_reg   <= digit_wrap ? '0 : digit_cnt_reg + 1'b1;
         digit_idx_reg   <= digit_wrap ? digit_idx_reg + 3'h1 : digit_idx_reg;
         blink_cnt_reg   <= blink_wrap ? '0 : blink_cnt_reg + 1'b1;
         blink_phase_reg <= blink_wrap ? !blink_phase_reg : blink_phase_reg;
      end
   end

   // Output stage, aligned with the registered store read
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         idx_d1_reg        <= 3'h0;
         segment_drive_reg <= 8'h00;
         digit_enable_reg  <= 8'h00;
         rd_data_reg       <= 8'h00;
      end
      else
      begin
         idx_d1_reg        <= digit_idx_reg;
         segment_drive_reg <= seg_next;
         digit_enable_reg  <= enable_next;
         rd_data_reg       <= rd_next;
      end
   end

   assign segment_drive = segment_drive_reg;
   assign digit_enable  = digit_enable_reg;
   assign blink_phase   = blink_phase_reg;
   assign rd_data       = rd_data_reg;

   property p_select_store;
      @(posedge clk_sys) disable iff (!rstn)
      sel_wr |=> digit_decode_select_reg == $past(wr_data);
   endproperty
   a_select_store: assert property (p_select_store) else $error("decode select not stored");

   property p_raw_path;
      @(posedge clk_sys) disable iff (!rstn)
      !decode_on |=> segment_drive_reg == $past(mem_q);
   endproperty
   a_raw_path: assert property (p_raw_path) else $error("raw digit altered");

   property p_font_zero;
      @(posedge clk_sys) disable iff (!rstn)
      (decode_on && mem_q[3:0] == 4'h0) |=> segment_drive_reg[6:0] == 7'h7e;
   endproperty
   a_font_zero: assert property (p_font_zero) else $error("font zero wrong");

   property p_font_b;
      @(posedge clk_sys) disable iff (!rstn)
      (decode_on && mem_q[3:0] == 4'hb) |=> segment_drive_reg[6:0] == 7'h1f;
   endproperty
   a_font_b: assert property (p_font_b) else $error("font b wrong");

   property p_point;
      @(posedge clk_sys) disable iff (!rstn)
      decode_on |=> segment_drive_reg[SEG_POINT_BIT] == $past(mem_q[SEG_POINT_BIT]);
   endproperty
   a_point: assert property (p_point) else $error("point segment wrong");

   property p_raw_point;
      @(posedge clk_sys) disable iff (!rstn)
      (!decode_on && mem_q[7]) |=> segment_drive_reg[7] && digit_enable_reg == (8'h01 << $past(idx_d1_reg));
   endproperty
   a_raw_point: assert property (p_raw_point) else $error("raw point or digit wrong");

   property p_restart;
      @(posedge clk_sys) disable iff (!rstn)
      (ctrl_wr_sync ##1 (!cs_n && !wr_en) ##1 (cs_n && !cs_prev_reg))
      |=> digit_idx_reg == 3'h0 && digit_cnt_reg == '0 && blink_cnt_reg == '0 && !blink_phase_reg;
   endproperty
   a_restart: assert property (p_restart) else $error("sync did not clear counters");

   property p_blink_toggle;
      @(posedge clk_sys) disable iff (!rstn)
      (blink_phase_reg != $past(blink_phase_reg) && !$past(restart_now))
      |-> $past(blink_cnt_reg) >= $past(blink_last) && $past(mux_rise);
   endproperty
   a_blink_toggle: assert property (p_blink_toggle) else $error("blink toggled early");

   property p_digit_hold;
      @(posedge clk_sys) disable iff (!rstn)
      (!mux_rise && !restart_now) |=> $stable(digit_idx_reg) && $stable(blink_cnt_reg);
   endproperty
   a_digit_hold: assert property (p_digit_hold) else $error("scan moved without clock");
endmodule
`default_nettype wire

// ===== led_digit_pkg.sv
// Constants shared by the digit segment decoder and its digit store.
// Assumes a byte-wide register write port fed by the serial front end.
package led_digit_pkg;
   localparam int          DIGIT_COUNT          = 8;
   localparam logic [7:0]  ADDR_DECODE_SELECT   = 8'h01;
   localparam logic [7:0]  ADDR_CONTROL         = 8'h04;
   localparam logic [7:0]  ADDR_STATUS          = 8'h05;
   localparam logic [7:0]  ADDR_DIGIT_BASE      = 8'h60;
   localparam logic [7:0]  DECODE_SELECT_RESET  = 8'h00;
   localparam logic [7:0]  CONTROL_RESET        = 8'h00;
   localparam int          CTRL_RATE_BIT        = 2;
   localparam int          CTRL_SYNC_BIT        = 5;
   localparam int          SEG_POINT_BIT        = 7;
   localparam int          DIGIT_NIBBLE_MSB     = 3;
   // Multiplex timing, in edges of the multiplex clock input
   localparam int          MUXCLK_PER_FRAME     = 6400;
   localparam int          MUXCLK_PER_DIGIT     = MUXCLK_PER_FRAME / DIGIT_COUNT;
   localparam longint      MUXCLK_NOMINAL_HZ    = 4000000;
   localparam longint      BLINK_SLOW_MHZ       = 500;
   localparam longint      BLINK_FAST_MHZ       = 1000;
   localparam int          BLINK_SLOW_HALF      = int'((MUXCLK_NOMINAL_HZ * 1000) / (2 * BLINK_SLOW_MHZ));
   localparam int          BLINK_FAST_HALF      = int'((MUXCLK_NOMINAL_HZ * 1000) / (2 * BLINK_FAST_MHZ));
   localparam int          DIGIT_CNT_W          = 10;
   localparam int          BLINK_CNT_W          = 23;
endpackage

// ===== digit_store.sv
// Eight-byte digit data store with one write port and a registered read.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module digit_store
   import led_digit_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        wr_en,
   input  wire logic [2:0]  wr_idx,
   input  wire logic [7:0]  wr_data,
   input  wire logic [2:0]  rd_idx,
   output logic      [7:0]  rd_q
);
   logic [7:0] mem_reg [DIGIT_COUNT];

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < DIGIT_COUNT; i++)
         begin
            mem_reg[i] <= 8'h00;
         end
         rd_q <= 8'h00;
      end
      else
      begin
         if (wr_en)
         begin
            mem_reg[wr_idx] <= wr_data;
         end
         rd_q <= mem_reg[rd_idx];
      end
   end
endmodule
`default_nettype wire

// ===== led_host_model.sv
// Host side model: byte writes framed by cs_n, plus the multiplex clock source.
// Assumes the bench supplies clk_sys at 200 MHz.
`timescale 1ns/100ps
`default_nettype none
module led_host_model
#(
   parameter int MUX_HALF = 16
)
(
   input  wire logic       clk_sys,
   output logic            wr_en,
   output logic [7:0]      wr_addr,
   output logic [7:0]      wr_data,
   output logic            cs_n,
   output logic            mux_clock_input
);
   initial
   begin
      wr_en = 1'b0;
      wr_addr = 8'h00;
      wr_data = 8'h00;
      cs_n = 1'b1;
      mux_clock_input = 1'b0;
   end

   // 6.25 MHz multiplex clock
   always
   begin
      repeat (MUX_HALF) @(posedge clk_sys);
      mux_clock_input <= ~mux_clock_input;
   end

   // Lines are inverted once released so stale values cannot match
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      cs_n <= 1'b0;
      @(posedge clk_sys);
      wr_en <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge clk_sys);
      wr_en <= 1'b0;
      wr_addr <= ~a;
      wr_data <= ~d;
      @(posedge clk_sys);
      cs_n <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ===== led_digit_segment_decoder_tb.sv
// Self-checking bench for the digit segment decoder.
// Assumes the host model drives the write port, cs_n and the multiplex clock.
`timescale 1ns/100ps
`default_nettype none
module led_digit_segment_decoder_tb
   import led_digit_pkg::*;
;
   typedef struct packed {logic [2:0] kind; logic [7:0] val;} note_type;
   localparam logic [2:0] K_SEG = 3'h0, K_EN = 3'h1, K_RD = 3'h2, K_PH = 3'h3, K_CNT = 3'h4;
   logic        clk_sys = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  rd_addr = 8'h00;
   logic        look = 1'b0;
   logic [7:0]  bl_n = 8'h00;
   logic [31:0] lfsr_state = 32'h5deb5643;
   wire         wr_en, cs_n, mux_clock_input, blink_phase;
   wire  [7:0]  wr_addr, wr_data, rd_data, segment_drive, digit_enable;
   note_type    q[$];
   note_type    e;
   int          err_total = 0;
   int          total_checks = 0;
   int          cyc = 0;
   logic [6:0]  font [16] = '{7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33, 7'h5b, 7'h5f, 7'h70,
                              7'h7f, 7'h7b, 7'h77, 7'h1f, 7'h4e, 7'h3f, 7'h4f, 7'h47};

   always #2.5 clk_sys = ~clk_sys;

   led_host_model #(.MUX_HALF(16)) host (.clk_sys(clk_sys), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data), .cs_n(cs_n), .mux_clock_input(mux_clock_input));
   led_digit_segment_decoder #(.SLOW_HALF(4), .FAST_HALF(2)) DUT (.clk_sys(clk_sys), .rstn(rstn),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .cs_n(cs_n),
      .mux_clock_input(mux_clock_input), .rd_addr(rd_addr), .rd_data(rd_data),
      .segment_drive(segment_drive), .digit_enable(digit_enable), .blink_phase(blink_phase));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic cmp8(input logic [7:0] got, input logic [7:0] want, input string what);
      total_checks++;
      if (got !== want)
      begin
         err_total++;
         $display("BAD %0t %s got %h want %h", $time, what, got, want);
      end
   endtask

   task automatic note(input logic [2:0] k, input logic [7:0] v);
      @(posedge clk_sys);
      q.push_back({k, v});
      look <= 1'b1;
      @(posedge clk_sys);
      look <= 1'b0;
   endtask

   // Multiplex clock rises between two blink phase changes
   task automatic blink_len;
      logic b;
      logic o;
      int   k;
      k = 0;
      repeat (2)
      begin
         b = blink_phase;
         bl_n = 8'h00;
         while (blink_phase === b && k < 5000)
         begin
            o = mux_clock_input;
            @(posedge clk_sys);
            k++;
            if (mux_clock_input && !o)
               bl_n++;
         end
      end
   endtask

   always @(posedge clk_sys)
   begin
      if (look)
      begin
         e = q.pop_front();
         case (e.kind)
            K_SEG: cmp8(segment_drive, e.val, "segment");
            K_EN: cmp8(digit_enable, e.val, "digit enable");
            K_RD: cmp8(rd_data, e.val, "readback");
            K_PH: cmp8({7'h00, blink_phase}, e.val, "blink phase");
            default: cmp8(bl_n, e.val, "blink length");
         endcase
      end
   end

   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         err_total++;
         test_done;
      end
   end

   initial
   begin
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      note(K_EN, 8'h01);
      note(K_SEG, 8'h00);
      $display("reset test ended");
      host.wr(ADDR_DECODE_SELECT, 8'h01);
      for (int c = 0; c < 16; c++)
      begin
         lfsr_state = lfsr(lfsr_state);
         host.wr(ADDR_DIGIT_BASE, {lfsr_state[7:4], c[3:0]});
         repeat (3) @(posedge clk_sys);
         note(K_SEG, {lfsr_state[7], font[c]});
      end
      $display("decode test ended");
      for (int i = 0; i < 8; i++)
      begin
         lfsr_state = lfsr(lfsr_state);
         host.wr(ADDR_DECODE_SELECT, i[0] ? 8'h00 : 8'hfe);
         host.wr(ADDR_DIGIT_BASE, lfsr_state[7:0]);
         repeat (3) @(posedge clk_sys);
         note(K_SEG, lfsr_state[7:0]);
      end
      $display("raw test ended");
      host.wr(ADDR_DECODE_SELECT, 8'h02);
      host.wr(ADDR_DIGIT_BASE + 8'h01, 8'hc7);
      rd_addr <= ADDR_DECODE_SELECT;
      note(K_RD, 8'h02);
      rd_addr <= 8'h02;
      note(K_RD, 8'h00);
      $display("readback test ended");
      blink_len;
      note(K_CNT, 8'd4);
      host.wr(ADDR_CONTROL, 8'h04);
      blink_len;
      note(K_CNT, 8'd2);
      $display("blink test ended");
      while (digit_enable === 8'h01 && cyc < 40000)
         @(posedge clk_sys);
      repeat (3) @(posedge clk_sys);
      note(K_EN, 8'h02);
      note(K_SEG, 8'hf0);
      host.wr(ADDR_CONTROL, 8'h20);
      repeat (3) @(posedge clk_sys);
      note(K_EN, 8'h01);
      note(K_PH, 8'h00);
      rd_addr <= ADDR_CONTROL;
      note(K_RD, 8'h20);
      rd_addr <= ADDR_STATUS;
      note(K_RD, 8'h00);
      $display("scan and sync test ended");
      test_done;
   end
endmodule
`default_nettype wire
